// File: cmsfc_map.vh
// Register offsets, field positions, reset values for the mode flag block
`ifndef CMSFC_MAP_VH
`define CMSFC_MAP_VH
// Byte offsets on the bus
`define CMSFC_OFS_DEF 8'h00
`define CMSFC_OFS_LAST 8'h04
`define CMSFC_OFS_ISTAT 8'h08
`define CMSFC_OFS_IMASK 8'h0C
`define CMSFC_OFS_TXREQ 8'h10
// Read positions in the definition register
`define CMSFC_B_DIAG 7
`define CMSFC_B_DPROC 6
`define CMSFC_B_SSHOT 5
`define CMSFC_B_PPRIO 4
`define CMSFC_B_BUS_ERROR_FLAG 3
`define CMSFC_B_VALID 2
`define CMSFC_B_WAKE 1
`define CMSFC_B_OVR 0
// Set positions of the four mode pairs, clear at set minus 8
`define CMSFC_S_DIAG 15
`define CMSFC_S_DPROC 14
`define CMSFC_S_SSHOT 13
`define CMSFC_S_PPRIO 12
`define CMSFC_PAIR_GAP 8
// Last event codes
`define CMSFC_ERR_NONE 4'h0
`define CMSFC_ERR_OVR 4'h7
`define CMSFC_ERR_WAKE 4'h8
`define CMSFC_LAST_RST 16'h00FF
// Interrupt status bits
`define CMSFC_EV_BUS_ERROR_FLAG 0
`define CMSFC_EV_VALID 1
`define CMSFC_EV_WAKE 2
`define CMSFC_EV_OVR 3
`define CMSFC_EV_TXDN 4
`define CMSFC_EV_W 5
// Transmit buffers and identifier width
`define CMSFC_NBUF 32
`define CMSFC_IDW 11
`endif

// File: cmsfc_irq.v
// Sticky interrupt status, read clear, mask and level output
`timescale 1ns/1ps
`default_nettype none
`include "cmsfc_map.vh"
module cmsfc_irq (
  input wire clk,
  input wire rst_n,
  input wire [`CMSFC_EV_W-1:0] evt,
  input wire rd_clr,
  input wire mask_we,
  input wire [`CMSFC_EV_W-1:0] mask_wdata,
  output reg [`CMSFC_EV_W-1:0] status_reg,
  output reg [`CMSFC_EV_W-1:0] mask_reg,
  output reg irq_reg
);
  wire [`CMSFC_EV_W-1:0] status_next;
  // New events win over a read clear in the same cycle
  assign status_next = (rd_clr ? {`CMSFC_EV_W{1'b0}} : status_reg) | evt;
  // Status, mask and interrupt level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= {`CMSFC_EV_W{1'b0}};
      mask_reg <= {`CMSFC_EV_W{1'b0}};
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (mask_we) begin
        mask_reg <= mask_wdata;
      end
      irq_reg <= |(status_next & (mask_we ? mask_wdata : mask_reg));
    end
  end
endmodule // cmsfc_irq
`default_nettype wire

// File: cmsfc_tx_arb.v
// Transmit arbiter: buffer position or lowest identifier
`timescale 1ns/1ps
`default_nettype none
`include "cmsfc_map.vh"
module cmsfc_tx_arb (
  input wire clk,
  input wire rst_n,
  input wire [`CMSFC_NBUF-1:0] pend,
  input wire pos_prio,
  input wire [`CMSFC_IDW-1:0] id_val,
  output reg [4:0] id_idx_reg,
  output reg win_valid_reg,
  output reg [4:0] win_idx_reg
);
  reg [`CMSFC_IDW-1:0] best_id_reg;
  reg [4:0] best_idx_reg;
  reg best_ok_reg;
  reg [4:0] low_idx;
  reg take;
  integer i;
  // Lowest pending buffer number
  always @* begin
    low_idx = 5'h1F;
    for (i = `CMSFC_NBUF - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        low_idx = i[4:0];
      end
    end
  end
  // Current scanned buffer beats best so far
  always @* begin
    take = pend[id_idx_reg] && (!best_ok_reg || id_val < best_id_reg);
  end
  // Identifier sweep, one buffer per cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_idx_reg <= 5'h00;
      best_id_reg <= {`CMSFC_IDW{1'b0}};
      best_idx_reg <= 5'h00;
      best_ok_reg <= 1'b0;
      win_valid_reg <= 1'b0;
      win_idx_reg <= 5'h00;
    end else begin
      id_idx_reg <= id_idx_reg + 5'h01;
      if (id_idx_reg == 5'h1F) begin
        best_ok_reg <= 1'b0;
      end else if (take) begin
        best_ok_reg <= 1'b1;
        best_id_reg <= id_val;
        best_idx_reg <= id_idx_reg;
      end
      if (pos_prio) begin
        win_valid_reg <= |pend;
        win_idx_reg <= low_idx;
      end else if (id_idx_reg == 5'h1F) begin
        win_valid_reg <= take | best_ok_reg;
        win_idx_reg <= take ? id_idx_reg : best_idx_reg;
      end
    end
  end
endmodule // cmsfc_tx_arb
`default_nettype wire

// File: cmsfc_top.v
// Mode and status set/clear register block with Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "cmsfc_map.vh"
module cmsfc_top (
  input wire SYS_CLK,
  input wire RESETN,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  input wire CAN_BUS_ERR,
  input wire [3:0] CAN_ERR_CODE,
  input wire CAN_RX_VALID,
  input wire [4:0] CAN_RX_BUF,
  input wire CAN_WAKE,
  input wire CAN_OVR,
  input wire CAN_TX_DONE,
  input wire CAN_TX_OK,
  input wire [10:0] CAN_ID_IN,
  output wire [4:0] CAN_ID_IDX,
  output reg TX_START,
  output reg [4:0] TX_BUF,
  output reg MODE_DIAG,
  output reg MODE_DIAG_PROC,
  output reg MODE_SINGLE_SHOT,
  output reg MODE_POS_PRIO,
  output reg ERR_IRQ,
  output wire IRQ
);
  // Mode pair update: set alone sets, clear alone clears
  function pair_next;
    input cur;
    input set_b;
    input clr_b;
    begin
      if (set_b && !clr_b) begin
        pair_next = 1'b1;
      end else if (!set_b && clr_b) begin
        pair_next = 1'b0;
      end else begin
        pair_next = cur;
      end
    end
  endfunction

  // Sticky flag: clear by write, hardware set wins
  function flag_next;
    input cur;
    input clr_b;
    input set_b;
    begin
      flag_next = (cur & ~clr_b) | set_b;
    end
  endfunction

  // Address match for one register offset
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr == ofs);
    end
  endfunction

  // Last-event reset value split into its code and buffer fields
  localparam [15:0] last_rst_val = `CMSFC_LAST_RST;
  localparam [3:0] last_err_rst = last_rst_val[11:8];
  localparam [7:0] last_rx_rst = last_rst_val[7:0];

  reg diag_select_bit_reg;
  reg diag_processing_bit_reg;
  reg single_shot_bit_reg;
  reg position_priority_bit_reg;
  reg bus_error_flag_reg;
  reg valid_flag_reg;
  reg wake_flag_reg;
  reg overrun_flag_reg;
  reg [3:0] last_err_reg;
  reg [7:0] last_rx_reg;
  reg [`CMSFC_NBUF-1:0] tx_req_reg;
  reg tx_busy_reg;
  reg [4:0] tx_cur_reg;
  wire acc;
  wire wr;
  wire rd;
  wire [31:0] byte_mask;
  wire [31:0] wdat;
  wire def_wr;
  wire wake_next;
  wire [`CMSFC_EV_W-1:0] irq_stat;
  wire [`CMSFC_EV_W-1:0] irq_mask;
  wire arb_valid;
  wire [4:0] arb_idx;
  reg [15:0] def_read;
  reg [31:0] rd_data;
  reg [`CMSFC_NBUF-1:0] tx_req_next;
  wire tx_launch;
  wire istat_rd;
  wire imask_wr;
  wire txreq_wr;

  // Bus strobes and byte lane masking
  assign acc = CYC_I & STB_I & ~ACK_O;
  assign wr = acc & WE_I;
  assign rd = acc & ~WE_I;
  assign byte_mask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign wdat = DAT_I & byte_mask;
  assign def_wr = wr && hit(ADR_I, `CMSFC_OFS_DEF);
  assign istat_rd = rd && hit(ADR_I, `CMSFC_OFS_ISTAT);
  assign imask_wr = wr && hit(ADR_I, `CMSFC_OFS_IMASK);
  assign txreq_wr = wr && hit(ADR_I, `CMSFC_OFS_TXREQ);

  // Interrupt unit: events, read clear and mask
  cmsfc_irq u_irq (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .evt({CAN_TX_DONE, CAN_OVR, CAN_WAKE, CAN_RX_VALID, CAN_BUS_ERR}),
    .rd_clr(istat_rd),
    .mask_we(imask_wr),
    .mask_wdata(wdat[`CMSFC_EV_W-1:0]),
    .status_reg(irq_stat),
    .mask_reg(irq_mask),
    .irq_reg(IRQ)
  );

  // Transmit arbiter
  cmsfc_tx_arb u_arb (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .pend(tx_req_reg),
    .pos_prio(position_priority_bit_reg),
    .id_val(CAN_ID_IN),
    .id_idx_reg(CAN_ID_IDX),
    .win_valid_reg(arb_valid),
    .win_idx_reg(arb_idx)
  );

  // Read view of the definition register
  always @* begin
    def_read = 16'h0000;
    def_read[`CMSFC_B_DIAG] = diag_select_bit_reg;
    def_read[`CMSFC_B_DPROC] = diag_processing_bit_reg;
    def_read[`CMSFC_B_SSHOT] = single_shot_bit_reg;
    def_read[`CMSFC_B_PPRIO] = position_priority_bit_reg;
    def_read[`CMSFC_B_BUS_ERROR_FLAG] = bus_error_flag_reg;
    def_read[`CMSFC_B_VALID] = valid_flag_reg;
    def_read[`CMSFC_B_WAKE] = wake_flag_reg;
    def_read[`CMSFC_B_OVR] = overrun_flag_reg;
  end

  // Read mux, unmapped reads as zero
  always @* begin
    case (ADR_I)
      `CMSFC_OFS_DEF: rd_data = {16'h0000, def_read};
      `CMSFC_OFS_LAST: rd_data = {16'h0000, 4'h0, last_err_reg, last_rx_reg};
      `CMSFC_OFS_ISTAT: rd_data = {27'h0000000, irq_stat};
      `CMSFC_OFS_IMASK: rd_data = {27'h0000000, irq_mask};
      `CMSFC_OFS_TXREQ: rd_data = tx_req_reg;
      default: rd_data = 32'h00000000;
    endcase
  end

  // Wishbone answer one cycle after the strobe
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= acc;
      if (rd) begin
        DAT_O <= rd_data;
      end
    end
  end

  // All pairs and clears of one write applied in one edge
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      diag_select_bit_reg <= 1'b0;
      diag_processing_bit_reg <= 1'b0;
      single_shot_bit_reg <= 1'b0;
      position_priority_bit_reg <= 1'b0;
    end else if (def_wr) begin
      diag_select_bit_reg <= pair_next(diag_select_bit_reg,
        wdat[`CMSFC_S_DIAG], wdat[`CMSFC_S_DIAG-`CMSFC_PAIR_GAP]);
      diag_processing_bit_reg <= pair_next(diag_processing_bit_reg,
        wdat[`CMSFC_S_DPROC], wdat[`CMSFC_S_DPROC-`CMSFC_PAIR_GAP]);
      single_shot_bit_reg <= pair_next(single_shot_bit_reg,
        wdat[`CMSFC_S_SSHOT], wdat[`CMSFC_S_SSHOT-`CMSFC_PAIR_GAP]);
      position_priority_bit_reg <= pair_next(position_priority_bit_reg,
        wdat[`CMSFC_S_PPRIO], wdat[`CMSFC_S_PPRIO-`CMSFC_PAIR_GAP]);
    end
  end

  // Wake flag next value, shared with the error interrupt
  assign wake_next = flag_next(wake_flag_reg, def_wr & wdat[`CMSFC_B_WAKE], CAN_WAKE);

  // Sticky status flags, engine events win over clears
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_error_flag_reg <= 1'b0;
      valid_flag_reg <= 1'b0;
      wake_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
      ERR_IRQ <= 1'b0;
    end else begin
      bus_error_flag_reg <= flag_next(bus_error_flag_reg,
        def_wr & wdat[`CMSFC_B_BUS_ERROR_FLAG], CAN_BUS_ERR);
      valid_flag_reg <= flag_next(valid_flag_reg,
        def_wr & wdat[`CMSFC_B_VALID], CAN_RX_VALID);
      wake_flag_reg <= wake_next;
      overrun_flag_reg <= flag_next(overrun_flag_reg,
        def_wr & wdat[`CMSFC_B_OVR], CAN_OVR);
      ERR_IRQ <= wake_next | CAN_OVR | CAN_BUS_ERR;
    end
  end

  // Last error code and last receive buffer
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      last_err_reg <= last_err_rst;
      last_rx_reg <= last_rx_rst;
    end else begin
      if (CAN_WAKE) begin
        last_err_reg <= `CMSFC_ERR_WAKE;
      end else if (CAN_OVR) begin
        last_err_reg <= `CMSFC_ERR_OVR;
      end else if (CAN_BUS_ERR) begin
        last_err_reg <= CAN_ERR_CODE;
      end
      if (CAN_RX_VALID) begin
        last_rx_reg <= {3'b000, CAN_RX_BUF};
      end
    end
  end

  // Launch only when idle and the published winner is still pending
  assign tx_launch = !tx_busy_reg && arb_valid && tx_req_reg[arb_idx];

  // Pending requests: attempt end drops on success or in single shot, software write adds
  always @* begin
    tx_req_next = tx_req_reg;
    if (tx_busy_reg && CAN_TX_DONE && (single_shot_bit_reg || CAN_TX_OK)) begin
      tx_req_next[tx_cur_reg] = 1'b0;
    end
    if (txreq_wr) begin
      tx_req_next = tx_req_next | wdat;
    end
  end

  // Transmit launch toward the protocol engine
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_req_reg <= {`CMSFC_NBUF{1'b0}};
      tx_busy_reg <= 1'b0;
      tx_cur_reg <= 5'h00;
      TX_START <= 1'b0;
      TX_BUF <= 5'h00;
    end else begin
      tx_req_reg <= tx_req_next;
      TX_START <= tx_launch;
      if (tx_launch) begin
        tx_busy_reg <= 1'b1;
        tx_cur_reg <= arb_idx;
        TX_BUF <= arb_idx;
      end else if (tx_busy_reg && CAN_TX_DONE) begin
        tx_busy_reg <= 1'b0;
      end
    end
  end

  // Mode outputs toward the protocol engine
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      MODE_DIAG <= 1'b0;
      MODE_DIAG_PROC <= 1'b0;
      MODE_SINGLE_SHOT <= 1'b0;
      MODE_POS_PRIO <= 1'b0;
    end else begin
      MODE_DIAG <= diag_select_bit_reg;
      MODE_DIAG_PROC <= diag_processing_bit_reg;
      MODE_SINGLE_SHOT <= single_shot_bit_reg;
      MODE_POS_PRIO <= position_priority_bit_reg;
    end
  end
endmodule // cmsfc_top
`default_nettype wire

// File: cmsfc_engine_model.sv
// Engine model: ends transmit attempts and supplies buffer identifiers
`timescale 1ns/1ps
`default_nettype none
module cmsfc_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_start,
  input wire logic [4:0] tx_buf,
  input wire logic [4:0] id_idx,
  output logic tx_done,
  output logic [10:0] id_in,
  output logic [4:0] first_buf
);
  logic [2:0] cnt_reg;
  logic seen_reg;
  // Higher index gets the lower identifier, opposite of position order
  assign id_in = 11'h7FF - {6'h00, id_idx};
  // Each attempt ends four cycles after its start pulse; first winner kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
      tx_done <= 1'b0;
      seen_reg <= 1'b0;
      first_buf <= 5'h1F;
    end else begin
      tx_done <= (cnt_reg == 3'h1);
      if (tx_start) cnt_reg <= 3'h3;
      else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      if (tx_start && !seen_reg) begin
        first_buf <= tx_buf;
        seen_reg <= 1'b1;
      end
    end
  end
endmodule // cmsfc_engine_model
`default_nettype wire

// File: cmsfc_chk_asserts.sv
// Checker for mode set/clear, bus answer and error interrupt timing
`timescale 1ns/1ps
`default_nettype none
module cmsfc_chk_asserts (
  input wire SYS_CLK,
  input wire RESETN,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  input wire ACK_O,
  input wire CAN_WAKE,
  input wire MODE_DIAG,
  input wire MODE_DIAG_PROC,
  input wire MODE_SINGLE_SHOT,
  input wire MODE_POS_PRIO,
  input wire ERR_IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // Write to the definition register taken on this edge
  wire tk = CYC_I & STB_I & WE_I & ~ACK_O & (ADR_I == 8'h00) & (SEL_I[1:0] == 2'b11);
  property p_diag_set; tk && DAT_I[15] && !DAT_I[7] |-> ##2 MODE_DIAG; endproperty
  a_diag_set: assert property (p_diag_set) else $error("diag mode not set");
  property p_diag_clr; tk && !DAT_I[15] && DAT_I[7] |=> ##1 !MODE_DIAG; endproperty
  a_diag_clr: assert property (p_diag_clr) else $error("diag mode not cleared");
  property p_diag_keep;
    tk && (DAT_I[15] == DAT_I[7]) |-> ##2 (MODE_DIAG == $past(MODE_DIAG, 2));
  endproperty
  a_diag_keep: assert property (p_diag_keep) else $error("diag mode changed");
  property p_dproc_set; tk && DAT_I[14] && !DAT_I[6] |-> ##2 MODE_DIAG_PROC; endproperty
  a_dproc_set: assert property (p_dproc_set) else $error("proc mode not set");
  property p_dproc_clr; tk && !DAT_I[14] && DAT_I[6] |=> ##1 !MODE_DIAG_PROC; endproperty
  a_dproc_clr: assert property (p_dproc_clr) else $error("proc mode not cleared");
  property p_sshot_set; tk && DAT_I[13] && !DAT_I[5] |-> ##2 MODE_SINGLE_SHOT; endproperty
  a_sshot_set: assert property (p_sshot_set) else $error("single shot not set");
  property p_sshot_clr; tk && !DAT_I[13] && DAT_I[5] |=> ##1 !MODE_SINGLE_SHOT; endproperty
  a_sshot_clr: assert property (p_sshot_clr) else $error("single shot not cleared");
  property p_pprio_set; tk && DAT_I[12] && !DAT_I[4] |-> ##2 MODE_POS_PRIO; endproperty
  a_pprio_set: assert property (p_pprio_set) else $error("priority not set");
  property p_pprio_clr; tk && !DAT_I[12] && DAT_I[4] |=> ##1 !MODE_POS_PRIO; endproperty
  a_pprio_clr: assert property (p_pprio_clr) else $error("priority not cleared");
  property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  property p_wake_irq; CAN_WAKE |=> ERR_IRQ; endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake did not raise error irq");
endmodule // cmsfc_chk_asserts
bind cmsfc_top cmsfc_chk_asserts u_chk (.SYS_CLK, .RESETN, .CYC_I, .STB_I, .WE_I, .ADR_I,
  .SEL_I, .DAT_I, .ACK_O, .CAN_WAKE, .MODE_DIAG, .MODE_DIAG_PROC, .MODE_SINGLE_SHOT,
  .MODE_POS_PRIO, .ERR_IRQ);
`default_nettype wire

// File: cmsfc_tb.sv
// Testbench for the mode flag set/clear block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, ev = 4'h0;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic ack, tx_start, tx_done, irq, err_irq, md, mdp, mss, mpp;
  logic [4:0] idx, tx_buf, first_buf;
  logic [10:0] id_in;
  int miscompares = 0, n_tests = 0, k;
  // Clock at 50 ns
  always #25 clk = ~clk;
  cmsfc_top dut (.SYS_CLK(clk), .RESETN(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .CAN_BUS_ERR(ev[3]),
    .CAN_ERR_CODE(4'h3), .CAN_RX_VALID(ev[2]), .CAN_RX_BUF(5'h0A), .CAN_WAKE(ev[1]),
    .CAN_OVR(ev[0]), .CAN_TX_DONE(tx_done), .CAN_TX_OK(1'b0), .CAN_ID_IN(id_in),
    .CAN_ID_IDX(idx), .TX_START(tx_start), .TX_BUF(tx_buf), .MODE_DIAG(md),
    .MODE_DIAG_PROC(mdp), .MODE_SINGLE_SHOT(mss), .MODE_POS_PRIO(mpp), .ERR_IRQ(err_irq),
    .IRQ(irq));
  cmsfc_engine_model u_eng (.clk(clk), .rst_n(rstn), .tx_start(tx_start), .tx_buf(tx_buf),
    .id_idx(idx), .tx_done(tx_done), .id_in(id_in), .first_buf(first_buf));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle; read data lands in q
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // One-cycle engine event pulse
  task pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    @(negedge clk);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wb(1, 8'h04, 32'h1234);
    wb(0, 8'h04, 0); chk(q, 32'h00FF);
    wb(0, 8'h40, 0); chk(q, 0);
    for (k = 0; k < 4; k++) begin
      wb(1, 8'h00, 32'h1 << (15 - k));
      wb(0, 8'h00, 0); chk(q & 32'hF0, 32'h1 << (7 - k));
      wb(1, 8'h00, (32'h1 << (15 - k)) | (32'h1 << (7 - k)));
      wb(1, 8'h00, 0);
      wb(0, 8'h00, 0); chk(q & 32'hF0, 32'h1 << (7 - k));
      wb(1, 8'h00, 32'h1 << (7 - k));
      wb(0, 8'h00, 0); chk(q & 32'hF0, 0);
    end
    wb(1, 8'h00, 32'hF000);
    wb(0, 8'h00, 0); chk(q & 32'hF0, 32'hF0);
    chk({md, mdp, mss, mpp}, 4'hF);
    wb(1, 8'h00, 32'h50A0);
    wb(0, 8'h00, 0); chk(q & 32'hF0, 32'h50);
    wb(1, 8'h00, 32'h00F0);
    for (k = 0; k < 4; k++) begin
      pulse(k);
      wb(0, 8'h00, 0); chk(q & 32'hF, 32'h1 << k);
      if (k == 1) chk(err_irq, 1);
      wb(1, 8'h00, 0);
      wb(0, 8'h00, 0); chk(q & 32'hF, 32'h1 << k);
      wb(1, 8'h00, 32'h1 << k);
      wb(0, 8'h00, 0); chk(q & 32'hF, 0);
      if (k == 1) chk(err_irq, 0);
    end
    wb(0, 8'h04, 0); chk(q, 32'h030A);
    wb(0, 8'h08, 0);
    wb(1, 8'h0C, 32'h1);
    pulse(3);
    chk(irq, 1);
    wb(0, 8'h08, 0); chk(q, 32'h1);
    wb(0, 8'h08, 0); chk(q, 0);
    chk(irq, 0);
    wb(1, 8'h0C, 0);
    pulse(3);
    chk(irq, 0);
    // Position priority, no single shot: failed attempts keep requests pending
    wb(1, 8'h00, 32'h1000);
    wb(1, 8'h10, 32'h28);
    repeat (40) @(posedge clk);
    chk(first_buf, 5'h03);
    wb(0, 8'h10, 0); chk(q, 32'h28);
    // Single shot on: each request dropped after one attempt
    wb(1, 8'h00, 32'h2000);
    repeat (40) @(posedge clk);
    wb(0, 8'h10, 0); chk(q, 0);
    chk(tx_buf, 5'h05);
    // Identifier order: buffer 5 has the lower identifier, so 3 goes last
    wb(1, 8'h00, 32'h0010);
    wb(1, 8'h10, 32'h28);
    repeat (200) @(posedge clk);
    wb(0, 8'h10, 0); chk(q, 0);
    chk(tx_buf, 5'h03);
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
